// ==== include/sdt_regs.svh ====
// register offsets, field positions and reset values of the serial transceiver event block
// assumes a 12-bit byte address on apb with 32-bit aligned words
//
// Overview of operation
// - flags for receiver started, transmitter started, transmitter stopped; read 1 when generated.
// - receive-start shortcut set: buffer-full event triggers the receiver start task.
// - receive-stop shortcut set: buffer-full event triggers the receiver stop task.
// - one read/write interrupt enable bit per event; 1 lets it interrupt.
// - writing 1 to enable-clear view disables; reads return enable state.
// - error cause readable; writing one clears a bit, zero leaves it.
// - start bit while holding register full sets overrun.
// - with parity checking on, bad parity sets parity error.
// - no valid stop bit after a character sets framing error.
// - line low longer than a frame (10 or 11 bits) sets break.
// - enable field 0 turns transceiver off, 8 turns it on.
`ifndef SDT_REGS_SVH
`define SDT_REGS_SVH

// event flags occupy 0x100..0x17c, one word per interrupt bit position
`define SDT_EVT_PAGE 5'h02
`define SDT_EVT_MASK 32'h005a_0397
`define SDT_EVT_ERR_BIT 9
`define SDT_EVT_ERR_ONE 32'h0000_0200
`define SDT_EVT_RXFULL_BIT 4
`define SDT_FLAG_RX_STARTED 12'h14c
`define SDT_FLAG_TX_STARTED 12'h150
`define SDT_FLAG_TX_STOPPED 12'h158

`define SDT_SHORTCUT 12'h200
`define SDT_SHORT_START_BIT 5
`define SDT_SHORT_STOP_BIT 6
`define SDT_IRQ_EN 12'h300
`define SDT_IRQ_SET 12'h304
`define SDT_IRQ_CLR 12'h308
`define SDT_ERRSRC 12'h480
`define SDT_ENABLE 12'h500
`define SDT_CONFIG 12'h56c

// field values
`define SDT_ENABLE_ON 4'h8
`define SDT_PARITY_LSB 1
`define SDT_PARITY_ON 3'h7
`define SDT_RESET_WORD 32'h0000_0000

// frame length in bit times, for break detection
`define SDT_FRAME_BITS 4'ha
`define SDT_FRAME_BITS_PAR 4'hb

`endif

// ==== include/sdt_pkg.sv ====
// shared types of the serial transceiver event block
// assumes the register header defines the offsets
package sdt_pkg;
  typedef logic [31:0] sdt_word_t;
  // positions inside the error cause register
  typedef enum int {
    SDT_ERR_OVERRUN,
    SDT_ERR_PARITY,
    SDT_ERR_FRAMING,
    SDT_ERR_BREAK
  } sdt_err_idx_t;
  typedef logic [3:0] sdt_err_t;
endpackage : sdt_pkg

// ==== include/sdt_line_if.sv ====
// carrier between the register core and the receive line monitor
// assumes both ends sit on REF_CLK
`timescale 1ns/1ns
`default_nettype none
interface sdt_line_if;
  logic on;
  logic par_en;
  sdt_pkg::sdt_err_t err;
  // monitor reports error pulses, core supplies configuration
  modport mon (input on, input par_en, output err);
  modport core (output on, output par_en, input err);
endinterface : sdt_line_if
`default_nettype wire

// ==== rtl/sdt_line_mon.sv ====
// receive line monitor: overrun, parity, framing and break detection
// assumes shifter strobes on REF_CLK and a raw asynchronous receive pin
`timescale 1ns/1ns
`default_nettype none
`include "sdt_regs.svh"
module sdt_line_mon (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pin and shifter strobes
  input wire logic rxd_pin,
  input wire logic bit_tick,
  input wire logic rx_idle,
  input wire logic rx_hold_full,
  input wire logic rx_char_done,
  input wire logic rx_parity_ok,
  // error reports
  sdt_line_if.mon lif
);
  logic sync1_r;
  logic sync2_r;
  logic line_r;
  logic [3:0] low_cnt_r;
  logic [3:0] low_cnt_nxt;
  logic brk_done_r;
  sdt_pkg::sdt_err_t err_r;
  sdt_pkg::sdt_err_t err_nxt;
  logic [3:0] frame_len;
  logic fall;
  logic low_over;

  // two-stage synchroniser, then a delayed copy for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      line_r <= 1'b1;
    end else begin
      sync1_r <= rxd_pin;
      sync2_r <= sync1_r;
      line_r <= sync2_r;
    end
  end

  // detections, all gated by the transceiver being on
  assign fall = line_r & ~sync2_r & rx_idle;
  assign frame_len = lif.par_en ? `SDT_FRAME_BITS_PAR : `SDT_FRAME_BITS;
  assign low_over = ~sync2_r & bit_tick & (low_cnt_r == frame_len) & ~brk_done_r;
  assign low_cnt_nxt = sync2_r ? 4'h0 :
                       (bit_tick & (low_cnt_r != frame_len)) ? 4'(low_cnt_r + 4'h1) : low_cnt_r;
  always_comb begin
    err_nxt = '0;
    err_nxt[sdt_pkg::SDT_ERR_OVERRUN] = lif.on & fall & rx_hold_full;
    err_nxt[sdt_pkg::SDT_ERR_PARITY] = lif.on & lif.par_en & rx_char_done & ~rx_parity_ok;
    err_nxt[sdt_pkg::SDT_ERR_FRAMING] = lif.on & rx_char_done & ~sync2_r;
    err_nxt[sdt_pkg::SDT_ERR_BREAK] = lif.on & low_over;
  end

  // low-time counter; one break report per low period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 4'h0;
      brk_done_r <= 1'b0;
      err_r <= '0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      brk_done_r <= ~sync2_r & (brk_done_r | low_over);
      err_r <= err_nxt;
    end
  end

  assign lif.err = err_r;
endmodule : sdt_line_mon
`default_nettype wire

// ==== rtl/sdt_evt_regs.sv ====
// event flags, shortcuts, interrupt enables and error cause of the serial transceiver
// assumes an apb master on REF_CLK and datapath event pulses on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "sdt_regs.svh"
module sdt_evt_regs (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // datapath event pulses, laid out as the interrupt enable bits
  input wire logic [31:0] EV_PULSE,
  // receive shifter status and strobes
  input wire logic BIT_TICK,
  input wire logic RX_IDLE,
  input wire logic RX_HOLD_FULL,
  input wire logic RX_CHAR_DONE,
  input wire logic RX_PARITY_OK,
  // serial receive pin
  input wire logic RXD_PIN,
  // task triggers and status
  output logic RX_START_TASK,
  output logic RX_STOP_TASK,
  output logic TRX_ON,
  output logic IRQ
);

  sdt_line_if lif();

  // register state
  sdt_pkg::sdt_word_t evt_r;
  sdt_pkg::sdt_word_t evt_nxt;
  sdt_pkg::sdt_word_t irq_en_r;
  sdt_pkg::sdt_word_t irq_en_nxt;
  logic [1:0] shortcut_ctrl_r;
  logic [1:0] shortcut_ctrl_nxt;
  sdt_pkg::sdt_err_t errsrc_r;
  sdt_pkg::sdt_err_t errsrc_nxt;
  logic [3:0] enable_r;
  logic [3:0] enable_nxt;
  logic [2:0] parity_r;
  logic [2:0] parity_nxt;

  // bus and output flops
  sdt_pkg::sdt_word_t prdata_r;
  sdt_pkg::sdt_word_t prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic start_task_r;
  logic start_task_nxt;
  logic stop_task_r;
  logic stop_task_nxt;
  logic on_r;
  logic irq_r;
  logic irq_nxt;

  // decode wires
  logic access;
  logic respond;
  logic wr;
  logic aligned;
  logic [4:0] evt_idx;
  sdt_pkg::sdt_word_t evt_sel;
  logic hit_evt;
  logic hit_shortcut_ctrl;
  logic hit_irq_en;
  logic hit_irq_set;
  logic hit_irq_clr;
  logic hit_errsrc;
  logic hit_enable;
  logic hit_config;
  logic hit_any;
  sdt_pkg::sdt_word_t rd_data;
  sdt_pkg::sdt_word_t evt_wr_oh;
  sdt_pkg::sdt_word_t hw_set;
  logic err_any;
  logic rx_full;
  logic on;

  // write strobes, one per register
  logic wr_evt;
  logic wr_shortcut_ctrl;
  logic wr_irq_en;
  logic wr_irq_set;
  logic wr_irq_clr;
  logic wr_errsrc;
  logic wr_enable;
  logic wr_config;
  sdt_pkg::sdt_err_t err_clr;

  // apb phases: first access cycle raises ready, the next edge takes the transfer
  assign access = PSEL & PENABLE;
  assign respond = access & ~pready_r;
  assign wr = access & pready_r & PWRITE;
  assign aligned = PADDR[1:0] == 2'b00;

  // address decode
  assign evt_idx = PADDR[6:2];
  assign evt_sel = sdt_pkg::sdt_word_t'(1) << evt_idx;
  assign hit_evt = aligned & (PADDR[11:7] == `SDT_EVT_PAGE) & |(evt_sel & `SDT_EVT_MASK);
  assign hit_shortcut_ctrl = PADDR == `SDT_SHORTCUT;
  assign hit_irq_en = PADDR == `SDT_IRQ_EN;
  assign hit_irq_set = PADDR == `SDT_IRQ_SET;
  assign hit_irq_clr = PADDR == `SDT_IRQ_CLR;
  assign hit_errsrc = PADDR == `SDT_ERRSRC;
  assign hit_enable = PADDR == `SDT_ENABLE;
  assign hit_config = PADDR == `SDT_CONFIG;
  assign hit_any = hit_evt | hit_shortcut_ctrl | hit_irq_en | hit_irq_set | hit_irq_clr |
                   hit_errsrc | hit_enable | hit_config;

  // write strobes: only the taking edge of a mapped write changes state
  assign wr_evt = wr & hit_evt;
  assign wr_shortcut_ctrl = wr & hit_shortcut_ctrl;
  assign wr_irq_en = wr & hit_irq_en;
  assign wr_irq_set = wr & hit_irq_set;
  assign wr_irq_clr = wr & hit_irq_clr;
  assign wr_errsrc = wr & hit_errsrc;
  assign wr_enable = wr & hit_enable;
  assign wr_config = wr & hit_config;
  assign err_clr = wr_errsrc ? PWDATA[3:0] : 4'h0;

  // read selection; unused bits read zero
  assign rd_data =
    hit_evt ? {31'h0, |(evt_r & evt_sel)} :
    hit_shortcut_ctrl ? (32'({shortcut_ctrl_r[1], shortcut_ctrl_r[0]}) << `SDT_SHORT_START_BIT) :
    (hit_irq_en | hit_irq_set | hit_irq_clr) ? irq_en_r :
    hit_errsrc ? {28'h0, errsrc_r} :
    hit_enable ? {28'h0, enable_r} :
    hit_config ? (32'(parity_r) << `SDT_PARITY_LSB) :
    `SDT_RESET_WORD;

  // bus answer: ready one cycle into the access phase, error on unmapped address
  assign pready_nxt = respond;
  assign pslverr_nxt = respond & ~hit_any;
  assign prdata_nxt = (respond & ~PWRITE) ? rd_data : `SDT_RESET_WORD;

  // derived state
  assign on = enable_r == `SDT_ENABLE_ON;
  assign err_any = |lif.err;
  assign rx_full = EV_PULSE[`SDT_EVT_RXFULL_BIT];

  // hardware event sets; the error event comes from the line monitor only
  assign hw_set = ((EV_PULSE & ~`SDT_EVT_ERR_ONE) |
                   (err_any ? `SDT_EVT_ERR_ONE : `SDT_RESET_WORD)) & `SDT_EVT_MASK;
  assign evt_wr_oh = wr_evt ? evt_sel : `SDT_RESET_WORD;

  // event flags: software writes bit 0, a coinciding event wins
  assign evt_nxt = ((evt_r & ~evt_wr_oh) | (evt_wr_oh & {32{PWDATA[0]}}) | hw_set) &
                   `SDT_EVT_MASK;

  // one enable state behind the three views
  assign irq_en_nxt =
    wr_irq_en ? (PWDATA & `SDT_EVT_MASK) :
    wr_irq_set ? (irq_en_r | (PWDATA & `SDT_EVT_MASK)) :
    wr_irq_clr ? (irq_en_r & ~PWDATA) :
    irq_en_r;

  // shortcut bits
  assign shortcut_ctrl_nxt = wr_shortcut_ctrl ?
                      {PWDATA[`SDT_SHORT_STOP_BIT], PWDATA[`SDT_SHORT_START_BIT]} : shortcut_ctrl_r;

  // error cause: write one clears, a new detection wins
  assign errsrc_nxt = (errsrc_r & ~err_clr) | lif.err;

  // enable field and parity configuration
  assign enable_nxt = wr_enable ? PWDATA[3:0] : enable_r;
  assign parity_nxt = wr_config ? PWDATA[`SDT_PARITY_LSB +: 3] : parity_r;

  // task triggers from the buffer-full event, suppressed while off; interrupt level
  assign start_task_nxt = on & rx_full & shortcut_ctrl_r[0];
  assign stop_task_nxt = on & rx_full & shortcut_ctrl_r[1];
  assign irq_nxt = |(evt_r & irq_en_r);

  // configuration to the line monitor
  assign lif.on = on;
  assign lif.par_en = parity_r == `SDT_PARITY_ON;

  sdt_line_mon u_mon (
    .clk(REF_CLK),
    .rst_n(NRST),
    .rxd_pin(RXD_PIN),
    .bit_tick(BIT_TICK),
    .rx_idle(RX_IDLE),
    .rx_hold_full(RX_HOLD_FULL),
    .rx_char_done(RX_CHAR_DONE),
    .rx_parity_ok(RX_PARITY_OK),
    .lif(lif.mon)
  );

  // event flags
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      evt_r <= `SDT_RESET_WORD;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // interrupt enable state
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_en_r <= `SDT_RESET_WORD;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end

  // shortcut bits
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      shortcut_ctrl_r <= 2'h0;
    end else begin
      shortcut_ctrl_r <= shortcut_ctrl_nxt;
    end
  end

  // error cause
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      errsrc_r <= 4'h0;
    end else begin
      errsrc_r <= errsrc_nxt;
    end
  end

  // enable field
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      enable_r <= 4'h0;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // parity configuration
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      parity_r <= 3'h0;
    end else begin
      parity_r <= parity_nxt;
    end
  end

  // read data, zero outside the ready cycle of a read
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_r <= `SDT_RESET_WORD;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // ready pulse, one per transfer
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  // bus error, only together with ready
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  // receiver start task pulse
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      start_task_r <= 1'b0;
    end else begin
      start_task_r <= start_task_nxt;
    end
  end

  // receiver stop task pulse
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      stop_task_r <= 1'b0;
    end else begin
      stop_task_r <= stop_task_nxt;
    end
  end

  // transceiver on status
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      on_r <= 1'b0;
    end else begin
      on_r <= on;
    end
  end

  // interrupt level, one cycle behind the flags
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // outputs straight from flops
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign RX_START_TASK = start_task_r;
  assign RX_STOP_TASK = stop_task_r;
  assign TRX_ON = on_r;
  assign IRQ = irq_r;

endmodule : sdt_evt_regs
`default_nettype wire

// ==== bench/sdt_far_end.sv ====
// far-end serial transmitter: drives the receive wire of the block
// assumes the wire idles high, driven high by this model, when nothing is sent
`timescale 1ns/1ns
`default_nettype none
module sdt_far_end (
  // command from the bench
  input wire logic brk_req,
  // serial wire
  output logic rxd
);
  // line held low only while a low period is asked for, else idle high
  assign rxd = !brk_req;
endmodule : sdt_far_end
`default_nettype wire

// ==== bench/sdt_evt_chk.sv ====
// checker of bus timing, task pulses and enable decode of the event block
// assumes it is bound into sdt_evt_regs and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module sdt_evt_chk (
  // clock, reset and bus
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // events and status
  input wire logic [31:0] EV_PULSE,
  input wire logic RX_START_TASK,
  input wire logic RX_STOP_TASK,
  input wire logic TRX_ON,
  input wire logic IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // bus answer shape
  a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_one_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("wait state");
  a_ready_cause: assert property (PREADY |-> PSEL && PENABLE) else $error("ready unasked");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000) else $error("data leak");
  // shortcut task pulses follow the buffer-full event
  a_start_cause: assert property (RX_START_TASK |-> $past(EV_PULSE[4]) && TRX_ON)
    else $error("start task without cause");
  a_stop_cause: assert property (RX_STOP_TASK |-> $past(EV_PULSE[4]))
    else $error("stop task without cause");
  // enable field decode
  a_enable_on: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h500
    |-> ##2 TRX_ON == ($past(PWDATA[3:0], 2) == 4'h8)) else $error("enable decode");
  // main scenarios
  c_refused: cover property (PSLVERR);
  c_start: cover property (RX_START_TASK);
  c_irq: cover property (IRQ);
endmodule : sdt_evt_chk
bind sdt_evt_regs sdt_evt_chk u_chk (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EV_PULSE(EV_PULSE), .RX_START_TASK(RX_START_TASK),
  .RX_STOP_TASK(RX_STOP_TASK), .TRX_ON(TRX_ON), .IRQ(IRQ));
`default_nettype wire

// ==== bench/tb_sdt_evt_regs.sv ====
// self-checking bench of the event, interrupt and error-cause block
// assumes one apb wait state and a far-end model on the receive wire
`timescale 1ns/1ns
`default_nettype none
module tb_sdt_evt_regs;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, EV_PULSE = 32'h0000_0000, PRDATA, r;
  logic tick = 1'b0, idle = 1'b0, hold = 1'b0, done = 1'b0, par_ok = 1'b1, brk = 1'b0;
  logic RXD_PIN, PREADY, PSLVERR, st, sp, TRX_ON, IRQ, e;
  int n_errors = 0;
  int checks_done = 0;
  // clock
  always #5 REF_CLK = ~REF_CLK;
  // far end and design
  sdt_far_end far (.brk_req(brk), .rxd(RXD_PIN));
  sdt_evt_regs dut (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EV_PULSE(EV_PULSE), .BIT_TICK(tick), .RX_IDLE(idle),
    .RX_HOLD_FULL(hold), .RX_CHAR_DONE(done), .RX_PARITY_OK(par_ok), .RXD_PIN(RXD_PIN),
    .RX_START_TASK(st), .RX_STOP_TASK(sp), .TRX_ON(TRX_ON), .IRQ(IRQ));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask : rdchk
  task automatic pulse(input logic [31:0] v);
    @(posedge REF_CLK);
    EV_PULSE <= v;
    @(posedge REF_CLK);
    EV_PULSE <= 32'h0000_0000;
  endtask : pulse
  task automatic t_reset;
    logic [11:0] regs [7] = '{12'h14c, 12'h150, 12'h158, 12'h200, 12'h300, 12'h480, 12'h500};
    foreach (regs[i]) rdchk(regs[i], 32'h0000_0000);
    apb(1'b0, 12'h7fc, 32'h0000_0000);
    chk(e, 1'b1);
  endtask : t_reset
  task automatic t_events;
    logic [11:0] adr [3] = '{12'h14c, 12'h150, 12'h158};
    int bits [3] = '{19, 20, 22};
    apb(1'b1, 12'h300, 32'hffff_ffff);
    rdchk(12'h304, 32'h005a_0397);
    apb(1'b1, 12'h308, 32'hffff_ffff);
    rdchk(12'h300, 32'h0000_0000);
    apb(1'b1, 12'h304, 32'h0010_0000);
    rdchk(12'h308, 32'h0010_0000);
    foreach (adr[k]) begin
      pulse(32'h0000_0001 << bits[k]);
      rdchk(adr[k], 32'h0000_0001);
      chk(IRQ, k == 1);
      apb(1'b1, adr[k], 32'h0000_0000);
      rdchk(adr[k], 32'h0000_0000);
      chk(IRQ, 1'b0);
    end
  endtask : t_events
  task automatic t_short;
    apb(1'b1, 12'h500, 32'h0000_0008);
    repeat (2) @(posedge REF_CLK);
    chk(TRX_ON, 1'b1);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, 12'h200, s == 0 ? 32'h0000_0000 : 32'h0000_0010 << s);
      pulse(32'h0000_0010);
      #1 chk({st, sp}, s == 1 ? 2'b10 : s == 2 ? 2'b01 : 2'b00);
    end
    apb(1'b1, 12'h500, 32'h0000_0000);
    repeat (2) @(posedge REF_CLK);
    chk(TRX_ON, 1'b0);
    apb(1'b1, 12'h500, 32'h0000_0008);
  endtask : t_short
  task automatic t_errors;
    apb(1'b1, 12'h56c, 32'h0000_000e);
    par_ok <= 1'b0;
    @(posedge REF_CLK) done <= 1'b1;
    @(posedge REF_CLK) done <= 1'b0;
    rdchk(12'h480, 32'h0000_0002);
    rdchk(12'h124, 32'h0000_0001);
    brk <= 1'b1;
    par_ok <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    done <= 1'b1;
    @(posedge REF_CLK) done <= 1'b0;
    rdchk(12'h480, 32'h0000_0006);
    repeat (10) begin
      @(posedge REF_CLK) tick <= 1'b1;
      @(posedge REF_CLK) tick <= 1'b0;
    end
    rdchk(12'h480, 32'h0000_0006);
    repeat (2) begin
      @(posedge REF_CLK) tick <= 1'b1;
      @(posedge REF_CLK) tick <= 1'b0;
    end
    rdchk(12'h480, 32'h0000_000e);
    brk <= 1'b0;
    idle <= 1'b1;
    hold <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    brk <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    rdchk(12'h480, 32'h0000_000f);
    brk <= 1'b0;
    apb(1'b1, 12'h480, 32'h0000_0005);
    rdchk(12'h480, 32'h0000_000a);
  endtask : t_errors
  task automatic wrap_up;
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    repeat (4) @(posedge REF_CLK);
    NRST <= 1'b1;
    t_reset();
    t_events();
    t_short();
    t_errors();
    wrap_up();
  end
  // watchdog
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule : tb_sdt_evt_regs
`default_nettype wire
